// >>> rtl/tstc_pkg.sv
// Package with register map, field positions and types for the timer sync/trigger block.
package tstc_pkg;

  localparam logic [7:0] ADDR_CTRL1   = 8'h00;
  localparam logic [7:0] ADDR_CTRL2   = 8'h04;
  localparam logic [7:0] ADDR_STATUS  = 8'h08;
  localparam logic [7:0] ADDR_TMR_LO  = 8'h0C;
  localparam logic [7:0] ADDR_TMR_HI  = 8'h10;
  localparam logic [7:0] ADDR_SYNC_IN = 8'h14;

  localparam int BIT_WIDTH_SEL  = 5;
  localparam int BIT_TIMER_ON   = 15;
  localparam int CLKSEL_LSB     = 8;
  localparam int BIT_TRIG_MODE  = 7;
  localparam int BIT_TRIG_ACT   = 7;
  localparam int BIT_TRIG_CLR   = 5;
  localparam int BIT_TRIG_ARMED = 6;

  localparam logic [4:0]  SYNC_NONE   = 5'h1F;
  localparam logic [2:0]  CLKSEL_SYS  = 3'h0;
  localparam logic [15:0] HALF_ZERO   = 16'h0000;
  localparam logic [15:0] HALF_ONE    = 16'h0001;
  localparam logic [15:0] HALF_MAX    = 16'hFFFF;
  localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;

  typedef enum logic [1:0] {
    TSTC_IDLE   = 2'b01,
    TSTC_ACCESS = 2'b10
  } tstc_bus_state_t;

  typedef struct packed {
    tstc_bus_state_t bus;
    logic            pready;
    logic [31:0]     prdata;
    logic            pslverr;
    logic            timer_on;
    logic            width_sel;
    logic [2:0]      clk_sel;
    logic            trig_mode;
    logic [4:0]      sync_sel;
    logic            trig_active;
    logic [15:0]     tmr_lo;
    logic [15:0]     tmr_hi;
    logic            lo_rollover;
    logic            hi_rollover;
  } tstc_state_t;

endpackage : tstc_pkg

// >>> rtl/tstc_timer_sync_trigger.sv
// Timer with sync and trigger control, reached over APB.
// Overview of operation
// - Sync and trigger work in both widths.
// - Five-bit field selects the external input.
// - Sync mode clears timer on selected input.
// - Counting restarts from zero unless held.
// - Trigger-mode enable clear selects sync operation.
// - Trigger mode holds zero until input arrives.
// - Trigger-mode enable set selects trigger operation.
// - Timer runs while trigger-active flag set.
// - Trigger clear resets; drops flag and holds zero unless a trigger arrives that cycle.
// - Width select: 0 dual 16, 1 single 32.
// - In dual 16 mode only primary timer reacts to sync source.
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
module tstc_timer_sync_trigger #(
  parameter int SYNC_INPUTS = 31
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [SYNC_INPUTS-1:0] sync_in,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  output logic                        trigger_active_flag,
  output logic                        primary_rollover,
  output logic                        secondary_rollover
);

  tstc_pkg::tstc_state_t s_q;
  tstc_pkg::tstc_state_t s_d;

  logic        sel_event;
  logic        run_lo;
  logic        clear_lo;
  logic        wr_status;
  logic        bus_commit;
  logic [31:0] rd_word;
  logic [31:0] ctrl1_word;
  logic [31:0] ctrl2_word;
  logic [31:0] status_word;

  // Code 5'h1F and codes beyond the implemented inputs select nothing.
  always_comb begin
    sel_event = 1'b0;
    if (s_q.sync_sel != tstc_pkg::SYNC_NONE && 32'(s_q.sync_sel) < SYNC_INPUTS) begin
      sel_event = sync_in[s_q.sync_sel];
    end
  end

  // A transfer completes at the edge where the master samples the registered pready high.
  // Writes and the trigger clear act only at that edge, never earlier.
  assign bus_commit = psel && penable && s_q.pready;

  assign wr_status = bus_commit && pwrite && paddr == tstc_pkg::ADDR_STATUS;

  always_comb begin
    ctrl1_word = tstc_pkg::WORD_ZERO;
    ctrl1_word[tstc_pkg::BIT_TIMER_ON] = s_q.timer_on;
    ctrl1_word[tstc_pkg::BIT_WIDTH_SEL] = s_q.width_sel;
    ctrl1_word[tstc_pkg::CLKSEL_LSB +: 3] = s_q.clk_sel;
    ctrl2_word = tstc_pkg::WORD_ZERO;
    ctrl2_word[tstc_pkg::BIT_TRIG_MODE] = s_q.trig_mode;
    ctrl2_word[4:0] = s_q.sync_sel;
    status_word = tstc_pkg::WORD_ZERO;
    status_word[tstc_pkg::BIT_TRIG_ACT] = s_q.trig_active;
    status_word[tstc_pkg::BIT_TRIG_ARMED] = s_q.trig_mode && !s_q.trig_active;
    if (paddr == tstc_pkg::ADDR_CTRL1) begin
      rd_word = ctrl1_word;
    end else if (paddr == tstc_pkg::ADDR_CTRL2) begin
      rd_word = ctrl2_word;
    end else if (paddr == tstc_pkg::ADDR_STATUS) begin
      rd_word = status_word;
    end else if (paddr == tstc_pkg::ADDR_TMR_LO) begin
      rd_word = {16'h0000, s_q.tmr_lo};
    end else if (paddr == tstc_pkg::ADDR_TMR_HI) begin
      rd_word = {16'h0000, s_q.tmr_hi};
    end else if (paddr == tstc_pkg::ADDR_SYNC_IN) begin
      rd_word = 32'(sync_in);
    end else begin
      rd_word = tstc_pkg::WORD_ZERO;
    end
  end

  // In dual 16-bit mode the primary half is the only one steered by the selected input; in 32-bit mode both halves are.
  always_comb begin
    clear_lo = 1'b0;
    run_lo   = s_q.timer_on;
    if (s_q.trig_mode) begin
      run_lo = s_q.timer_on && s_q.trig_active;
      if (wr_status && pwdata[tstc_pkg::BIT_TRIG_CLR]) begin
        clear_lo = 1'b1;
      end
    end else if (sel_event) begin
      clear_lo = 1'b1;
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    s_d.lo_rollover = 1'b0;
    s_d.hi_rollover = 1'b0;

    // The handshake raises pready one cycle after the access edge; read data and the error
    // flag are registered together with it so that they stand at the sampling edge.
    case (s_q.bus)
      tstc_pkg::TSTC_IDLE: begin
        if (psel && !penable) begin
          s_d.bus = tstc_pkg::TSTC_ACCESS;
        end
      end
      tstc_pkg::TSTC_ACCESS: begin
        if (psel && penable) begin
          s_d.pready = 1'b1;
          s_d.bus = tstc_pkg::TSTC_IDLE;
          if (!pwrite) begin
            s_d.prdata = rd_word;
          end
          // The input readback word is read-only, so a write to it is refused.
          if (pwrite && paddr == tstc_pkg::ADDR_SYNC_IN) begin
            s_d.pslverr = 1'b1;
          end
          if (!(paddr inside {tstc_pkg::ADDR_CTRL1, tstc_pkg::ADDR_CTRL2,
                              tstc_pkg::ADDR_STATUS, tstc_pkg::ADDR_TMR_LO,
                              tstc_pkg::ADDR_TMR_HI, tstc_pkg::ADDR_SYNC_IN})) begin
            s_d.pslverr = 1'b1;
          end
        end else begin
          s_d.bus = tstc_pkg::TSTC_IDLE;
        end
      end
      default: s_d.bus = tstc_pkg::TSTC_IDLE;
    endcase

    // A trigger that arrives in the same cycle as the clear request wins, so that no
    // trigger event is lost; the timer is still zeroed by the clear in that cycle.
    if (!s_q.trig_mode) begin
      s_d.trig_active = 1'b0;
    end else if (clear_lo) begin
      s_d.trig_active = sel_event;
    end else if (sel_event && !s_q.trig_active) begin
      s_d.trig_active = 1'b1;
    end
    if (clear_lo) begin
      s_d.tmr_lo = tstc_pkg::HALF_ZERO;
      if (s_q.width_sel) begin
        s_d.tmr_hi = tstc_pkg::HALF_ZERO;
      end
    end else if (s_q.trig_mode && !s_q.trig_active) begin
      s_d.tmr_lo = tstc_pkg::HALF_ZERO;
      if (s_q.width_sel) begin
        s_d.tmr_hi = tstc_pkg::HALF_ZERO;
      end
    end else if (run_lo) begin
      s_d.tmr_lo = s_q.tmr_lo + tstc_pkg::HALF_ONE;
      s_d.lo_rollover = s_q.tmr_lo == tstc_pkg::HALF_MAX;
      if (s_q.width_sel && s_q.tmr_lo == tstc_pkg::HALF_MAX) begin
        s_d.tmr_hi = s_q.tmr_hi + tstc_pkg::HALF_ONE;
        s_d.hi_rollover = s_q.tmr_hi == tstc_pkg::HALF_MAX;
      end
    end
    if (!s_q.width_sel && s_q.timer_on) begin
      s_d.tmr_hi = s_q.tmr_hi + tstc_pkg::HALF_ONE;
      s_d.hi_rollover = s_q.tmr_hi == tstc_pkg::HALF_MAX;
    end

    // Register writes come last so that a write to a running timer half is not
    // overwritten by the increment of that same cycle.
    // Writes land only at the edge where the master sees pready high.
    if (bus_commit && pwrite) begin
      if (paddr == tstc_pkg::ADDR_CTRL1) begin
        s_d.timer_on = pwdata[tstc_pkg::BIT_TIMER_ON];
        s_d.width_sel = pwdata[tstc_pkg::BIT_WIDTH_SEL];
        s_d.clk_sel = pwdata[tstc_pkg::CLKSEL_LSB +: 3];
      end else if (paddr == tstc_pkg::ADDR_CTRL2) begin
        s_d.trig_mode = pwdata[tstc_pkg::BIT_TRIG_MODE];
        s_d.sync_sel = pwdata[4:0];
      end else if (paddr == tstc_pkg::ADDR_TMR_LO) begin
        s_d.tmr_lo = pwdata[15:0];
      end else if (paddr == tstc_pkg::ADDR_TMR_HI) begin
        s_d.tmr_hi = pwdata[15:0];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{bus: tstc_pkg::TSTC_IDLE, clk_sel: tstc_pkg::CLKSEL_SYS,
               sync_sel: tstc_pkg::SYNC_NONE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign pready              = s_q.pready;
  assign prdata              = s_q.prdata;
  assign pslverr             = s_q.pslverr;
  assign trigger_active_flag = s_q.trig_active;
  assign primary_rollover    = s_q.lo_rollover;
  assign secondary_rollover  = s_q.hi_rollover;

endmodule : tstc_timer_sync_trigger

// >>> verif/tstc_sync_src.sv
// Model of the peripheral sources that feed the sync and trigger inputs.
`timescale 1ns/1ps
module tstc_sync_src (
  input  logic        ref_clk,
  input  logic [4:0]  sel,
  input  logic        fire,
  output logic [30:0] sync_in
);
  // Only the chosen line is driven high; all other sources stay idle.
  always_ff @(posedge ref_clk) begin
    sync_in <= fire ? (31'h1 << sel) : 31'h0;
  end
endmodule : tstc_sync_src

// >>> verif/tstc_sva_assertions.sv
// Checker bound to the timer ports.
`timescale 1ns/1ps
module tstc_sva #(
  parameter int SYNC_INPUTS = 31
) (
  input logic                   ref_clk,
  input logic                   rst,
  input logic                   psel,
  input logic                   penable,
  input logic                   pwrite,
  input logic [7:0]             paddr,
  input logic [31:0]            pwdata,
  input logic [SYNC_INPUTS-1:0] sync_in,
  input logic                   pready,
  input logic                   pslverr,
  input logic                   trigger_active_flag,
  input logic                   primary_rollover
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire acc = psel && penable && !pready;
  chk_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  chk_ready_time: assert property ($rose(penable) && psel |=> pready) else $error("pready late");
  chk_err_unmapped: assert property (acc && paddr > 8'h14 |=> pslverr && pready)
    else $error("no error on unmapped");
  chk_ok_mapped: assert property (acc && paddr <= 8'h14 && paddr[1:0] == 2'b00 |=> !pslverr)
    else $error("error on mapped");
  chk_flag_hold: assert property (trigger_active_flag && !(psel && pwrite) |=>
    trigger_active_flag) else $error("flag dropped");
  chk_flag_clear: assert property (psel && penable && pready && pwrite && paddr == 8'h08
    && pwdata[5] && !(|sync_in) |=> !trigger_active_flag) else $error("flag not cleared");
  chk_flag_cause: assert property ($rose(trigger_active_flag) |-> $past(|sync_in))
    else $error("flag without input");
  chk_roll_pulse: assert property (primary_rollover |=> !primary_rollover)
    else $error("rollover too long");
  cover property ($rose(trigger_active_flag));
  cover property (pslverr);
  cover property (primary_rollover);
endmodule : tstc_sva
bind tstc_timer_sync_trigger tstc_sva #(.SYNC_INPUTS(SYNC_INPUTS)) chk_i (.ref_clk, .rst,
  .psel, .penable, .pwrite, .paddr, .pwdata, .sync_in, .pready, .pslverr,
  .trigger_active_flag, .primary_rollover);

// >>> verif/tb_timer_sync_trigger_control.sv
// Testbench for the timer sync and trigger block.
`timescale 1ns/1ps
module tb_timer_sync_trigger_control;
  logic        ref_clk, rst, psel, penable, pwrite, fire, pready, pslverr, er, flag, sec_roll;
  int          n_sec;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0]  src;
  logic [30:0] sync_in;
  int          err_total, n_tests;
  tstc_timer_sync_trigger dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .sync_in(sync_in), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .trigger_active_flag(flag), .primary_rollover(),
    .secondary_rollover(sec_roll));
  always @(posedge ref_clk) if (sec_roll === 1'b1) n_sec <= n_sec + 1;
  tstc_sync_src src_m (.ref_clk(ref_clk), .sel(src), .fire(fire), .sync_in(sync_in));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic give_verdict;
    if (err_total == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  initial begin
    #3000000;
    err_total++;
    give_verdict();
  end
  initial begin
    {rst, psel, penable, pwrite, fire, paddr, pwdata, src, err_total, n_tests, n_sec} = '0;
    rst = 1'b1;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    apb(1'b0, tstc_pkg::ADDR_CTRL2, 32'h0);
    cmp(rd, 32'h1F);
    apb(1'b0, 8'h40, 32'h0);
    cmp({rd[30:0], er}, 32'h1);
    src <= 5'h03;
    fire <= 1'b1;
    apb(1'b1, tstc_pkg::ADDR_CTRL2, 32'h03);
    apb(1'b1, tstc_pkg::ADDR_CTRL1, 32'h8000);
    apb(1'b0, tstc_pkg::ADDR_TMR_LO, 32'h0);
    cmp(rd, 32'h0);
    fire <= 1'b0;
    apb(1'b0, tstc_pkg::ADDR_TMR_LO, 32'h0);
    cmp({31'h0, rd != 32'h0}, 32'h1);
    apb(1'b1, tstc_pkg::ADDR_CTRL2, 32'h83);
    apb(1'b0, tstc_pkg::ADDR_TMR_LO, 32'h0);
    cmp(rd, 32'h0);
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    apb(1'b0, tstc_pkg::ADDR_STATUS, 32'h0);
    cmp(rd & 32'h80, 32'h80);
    cmp({31'h0, flag}, 32'h1);
    apb(1'b0, tstc_pkg::ADDR_TMR_LO, 32'h0);
    cmp({31'h0, rd != 32'h0}, 32'h1);
    apb(1'b1, tstc_pkg::ADDR_STATUS, 32'h20);
    apb(1'b0, tstc_pkg::ADDR_STATUS, 32'h0);
    cmp(rd & 32'h80, 32'h0);
    cmp({31'h0, flag}, 32'h0);
    apb(1'b0, tstc_pkg::ADDR_TMR_LO, 32'h0);
    cmp(rd, 32'h0);
    apb(1'b1, tstc_pkg::ADDR_TMR_HI, 32'hFFF0);
    repeat (20) @(posedge ref_clk);
    cmp(n_sec, 32'h1);
    src <= 5'h04;
    apb(1'b1, tstc_pkg::ADDR_CTRL2, 32'h04);
    apb(1'b1, tstc_pkg::ADDR_CTRL1, 32'h8020);
    apb(1'b1, tstc_pkg::ADDR_TMR_HI, 32'h0);
    apb(1'b1, tstc_pkg::ADDR_TMR_LO, 32'hFFF0);
    repeat (20) @(posedge ref_clk);
    apb(1'b0, tstc_pkg::ADDR_TMR_HI, 32'h0);
    cmp(rd, 32'h1);
    fire <= 1'b1;
    apb(1'b0, tstc_pkg::ADDR_TMR_HI, 32'h0);
    cmp(rd, 32'h0);
    give_verdict();
  end
endmodule : tb_timer_sync_trigger_control
